/* hw/clk_ctl.sv */
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctl_map.svh"
module clk_ctl
   import clk_ctl_pkg::*;
#(
   parameter int MULT_W = 6
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        wakeReset_n,
   input  wire logic        power_good_n,
   output logic             coreClkEn,
   output logic             sysClkEn,
   output logic             clock_out_pin,
   output logic             clockOutOe,
   output logic             regulator_wake_out,
   output logic             bootStart
);
   localparam int BOOT_CYC = (`BOOT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   pll_cfg_t   pll_ff;
   div_cfg_t   div_ff;
   logic       outEn_ff, outSel_ff, hib_ff;
   pwr_state_t pwr_ff, nxt_pwr;
   logic [7:0] bootCnt_ff;
   wire        acc    = psel & penable;
   wire        wr     = acc & pwrite;
   wire        hitPll = paddr == `PLL_CTL_OFS;
   wire        hitDiv = paddr == `PLL_DIV_OFS;
   wire        hitGlb = paddr == `GLOBAL_CTL_OFS;
   wire        hitVr  = paddr == `VR_CTL_OFS;
   wire        hitSt  = paddr == `STATUS_OFS;
   wire        hitAny = hitPll | hitDiv | hitGlb | hitVr | hitSt;
   wire [31:0] rdMux  = hitPll ? {23'h0, pll_ff.bypass, 1'b0, pll_ff.mult, 1'b0} :
                        hitDiv ? {26'h0, div_ff.coreSel, div_ff.sysSel} :
                        hitGlb ? {30'h0, outSel_ff, outEn_ff} :
                        hitVr  ? {31'h0, hib_ff} :
                        hitSt  ? {28'h0, pwr_ff} : 32'h0;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~pready;
         pslverr <= psel & ~pready & ~hitAny;
         prdata  <= (psel & ~pwrite) ? rdMux : 32'h0;
      end
   end
   wire done = acc & pready;

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pll_ff.mult   <= `MSEL_RST;
         pll_ff.bypass <= 1'b0;
         div_ff.sysSel <= `SYSDIV_RST;
         div_ff.coreSel <= `COREDIV_RST;
         outEn_ff      <= 1'b1;
         outSel_ff     <= 1'b0;
         hib_ff        <= 1'b1;
      end else begin
         if (wr & done & hitPll) begin
            pll_ff.mult   <= pwdata[`MSEL_LSB +: `MSEL_W];
            pll_ff.bypass <= pwdata[`BYPASS_BIT];
         end
         if (wr & done & hitDiv) begin
            // zero is not a legal system ratio, keep divide by one
            div_ff.sysSel  <= (pwdata[`SYSDIV_LSB +: 4] == 4'h0) ? 4'h1 :
                              pwdata[`SYSDIV_LSB +: 4];
            div_ff.coreSel <= pwdata[`COREDIV_LSB +: 2];
         end
         if (wr & done & hitGlb) begin
            outEn_ff  <= pwdata[`PINOUT_EN_BIT];
            outSel_ff <= pwdata[`PINOUT_SEL_BIT];
         end
         if (wr & done & hitVr) hib_ff <= pwdata[`HIBERNATE_BIT];
         // wake request wins over a same-cycle clear
         if (pwr_ff == PW_HIBER && !wakeReset_n) hib_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pll: vco enable pulse as multiplied rate ratio over input clock
   // input clock is represented by one tick every pll_ff.mult clock cycles
   logic [MULT_W-1:0] inCnt_ff;
   wire  inTick = inCnt_ff == '0;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) inCnt_ff <= '0;
      else inCnt_ff <= inTick ? MULT_W'(pll_ff.mult - 6'h1) : inCnt_ff - 1'b1;
   end
   // bypass sends the input clock straight to both dividers
   wire vcoTick = pll_ff.bypass ? inTick : 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // dividers, reload only at their own boundary
   function automatic logic [3:0] coreRatio(input logic [1:0] sel);
      coreRatio = 4'h1 << sel;
   endfunction
   logic [3:0] sysCnt_ff, coreCnt_ff, sysLd_ff, coreLd_ff;
   wire        sysEdge  = vcoTick & (sysCnt_ff == 4'h1);
   wire        coreEdge = vcoTick & (coreCnt_ff == 4'h1);
   wire [3:0]  sysRatio  = pll_ff.bypass ? 4'h1 : div_ff.sysSel;
   wire [3:0]  coreRatioW = pll_ff.bypass ? 4'h1 : coreRatio(div_ff.coreSel);
   wire        running  = pwr_ff == PW_RUN || pwr_ff == PW_BOOT;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sysCnt_ff  <= 4'h1;
         coreCnt_ff <= 4'h1;
         sysLd_ff   <= 4'h1;
         coreLd_ff  <= 4'h1;
      end else begin
         if (sysEdge) sysLd_ff <= sysRatio;
         if (coreEdge) coreLd_ff <= coreRatioW;
         if (vcoTick) sysCnt_ff <= sysEdge ? sysRatio : sysCnt_ff - 4'h1;
         if (vcoTick) coreCnt_ff <= coreEdge ? coreRatioW : coreCnt_ff - 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock enables and output pin
   logic sysLvl_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         coreClkEn     <= 1'b0;
         sysClkEn      <= 1'b0;
         sysLvl_ff     <= 1'b0;
         clock_out_pin <= 1'b0;
         clockOutOe    <= 1'b1;
      end else begin
         coreClkEn  <= coreEdge & (pwr_ff == PW_RUN);
         sysClkEn   <= sysEdge & running;
         if (sysEdge) sysLvl_ff <= ~sysLvl_ff;
         clock_out_pin <= outSel_ff ? inTick : sysLvl_ff;
         clockOutOe <= outEn_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power sequencing
   always_comb begin
      nxt_pwr = pwr_ff;
      case (pwr_ff)
         PW_HIBER: if (hib_ff) nxt_pwr = PW_WAIT;
         PW_WAIT:  if (!power_good_n) nxt_pwr = PW_BOOT;
         PW_BOOT:  if (bootCnt_ff == 8'h0) nxt_pwr = PW_RUN;
         PW_RUN:   if (!hib_ff) nxt_pwr = PW_HIBER;
         default:  nxt_pwr = PW_HIBER;
      endcase
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pwr_ff             <= PW_WAIT;
         bootCnt_ff         <= 8'h0;
         regulator_wake_out <= 1'b1;
         bootStart          <= 1'b0;
      end else begin
         pwr_ff     <= nxt_pwr;
         bootCnt_ff <= (nxt_pwr == PW_BOOT && pwr_ff != PW_BOOT) ? 8'(BOOT_CYC) :
                       (bootCnt_ff != 8'h0 ? bootCnt_ff - 8'h1 : 8'h0);
         regulator_wake_out <= hib_ff;
         bootStart  <= pwr_ff == PW_WAIT && nxt_pwr == PW_BOOT;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_wake_follows_hib: assert property (@(posedge clk) disable iff (!resetn)
      $fell(hib_ff) |=> !regulator_wake_out) else $error("wake not dropped");
   a_pg_holds_start: assert property (@(posedge clk) disable iff (!resetn)
      bootStart |-> $past(!power_good_n)) else $error("boot without power good");
   a_hib_wakeup: assert property (@(posedge clk) disable iff (!resetn)
      (pwr_ff == PW_HIBER && !wakeReset_n) |-> ##2 regulator_wake_out)
      else $error("reset did not wake regulator");
   a_core_ratio: assert property (@(posedge clk) disable iff (!resetn)
      (coreEdge && !pll_ff.bypass && $stable(div_ff.coreSel) && div_ff.coreSel == 2'h3)
      |-> ##1 !coreEdge [*7]) else $error("core ratio wrong");
   a_sys_spacing: assert property (@(posedge clk) disable iff (!resetn)
      (sysEdge && !pll_ff.bypass && sysRatio == 4'h2) |=> !sysEdge ##1 sysEdge)
      else $error("system ratio wrong");
   a_bypass_rate: assert property (@(posedge clk) disable iff (!resetn)
      (pll_ff.bypass && sysCnt_ff == 4'h1) |-> (sysEdge == inTick))
      else $error("bypass rate wrong");
   a_out_disable: assert property (@(posedge clk) disable iff (!resetn)
      !outEn_ff |=> !clockOutOe) else $error("clock out not disabled");
   a_reload_edge: assert property (@(posedge clk) disable iff (!resetn)
      (sysCnt_ff != 4'h1 && vcoTick) |=> sysCnt_ff == $past(sysCnt_ff) - 4'h1)
      else $error("divider reloaded mid period");
   a_ready_pulse: assert property (@(posedge clk) disable iff (!resetn)
      pready |=> !pready) else $error("ready held too long");
   a_core_gated: assert property (@(posedge clk) disable iff (!resetn)
      coreClkEn |-> $past(pwr_ff == PW_RUN)) else $error("core clock outside run");
   a_wake_in_run: assert property (@(posedge clk) disable iff (!resetn)
      (pwr_ff == PW_RUN) |-> regulator_wake_out) else $error("run without power request");
   a_sys_reload: assert property (@(posedge clk) disable iff (!resetn)
      sysEdge |=> sysCnt_ff == $past(sysRatio)) else $error("system ratio not reloaded");
endmodule
`default_nettype wire

/* hw/clk_ctl_map.svh */
// Operation
// - core and system clocks come from a pll multiplier defaulting to six
// - system clock is pll output divided by a four-bit field, 1 to 15
// - a new system divider applies from the next system clock edge, no relock wait
// - core divider code 00/01/10/11 divides by 1/2/4/8
// - a divider register write outside pll bypass changes both clock rates on the fly
// - peripherals run from the system clock, core from the core clock
// - clock output pin drives system clock or buffered input clock
// - clock output active after reset, disabled by bus global control enable
// - regulator wake high requests core power, low asks for shutdown
// - reset input in hibernate raises regulator wake, then boot starts
// - start-up waits until the active-low power-good input is asserted
// - writing zero to the hibernate bit drives regulator wake low
// - pll bypass makes core and system clocks run at input clock rate
`ifndef CLK_CTL_MAP_SVH
`define CLK_CTL_MAP_SVH
`define PLL_CTL_OFS      12'h000
`define PLL_DIV_OFS      12'h004
`define GLOBAL_CTL_OFS   12'h008
`define VR_CTL_OFS       12'h00C
`define STATUS_OFS       12'h010
`define MSEL_LSB         1
`define MSEL_W           6
`define BYPASS_BIT       8
`define SYSDIV_LSB       0
`define COREDIV_LSB      4
`define PINOUT_EN_BIT    0
`define PINOUT_SEL_BIT   1
`define HIBERNATE_BIT    0
`define MSEL_RST         6'h06
`define SYSDIV_RST       4'h5
`define COREDIV_RST      2'h0
`define BOOT_DELAY_NS    200
`define CLK_PERIOD_NS    20
`endif

/* hw/clk_ctl_pkg.sv */
package clk_ctl_pkg;
   typedef struct packed {
      logic [5:0] mult;
      logic       bypass;
   } pll_cfg_t;
   typedef struct packed {
      logic [1:0] coreSel;
      logic [3:0] sysSel;
   } div_cfg_t;
   typedef enum logic [3:0] {
      PW_HIBER = 4'h1,
      PW_WAIT  = 4'h2,
      PW_BOOT  = 4'h4,
      PW_RUN   = 4'h8
   } pwr_state_t;
endpackage

/* tb/pll_clock_divider_and_regulator_wake_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctl_map.svh"
module pll_clock_divider_and_regulator_wake_tb_top
   import clk_ctl_pkg::*;
;
   logic        clk, resetn, psel, penable, pwrite, wakeReset_n, power_good_n, err;
   logic        pready, pslverr, coreClkEn, sysClkEn, clock_out_pin, clockOutOe;
   logic        regulator_wake_out, bootStart;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          nFail, numChecks, seen;
   logic [31:0] rstVal [5] = '{32'h0000000C, 32'h00000005, 32'h1, 32'h1, 32'h8};
   logic [3:0]  divSys [4] = '{4'h1, 4'hF, 4'h2, 4'h6};
   logic [1:0]  divCore [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
   clk_ctl uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wakeReset_n(wakeReset_n), .power_good_n(power_good_n),
      .coreClkEn(coreClkEn), .sysClkEn(sysClkEn), .clock_out_pin(clock_out_pin),
      .clockOutOe(clockOutOe), .regulator_wake_out(regulator_wake_out), .bootStart(bootStart));
   reg_model #(.RAMP(20)) regu (.clk(clk), .resetn(resetn),
      .regulator_wake_out(regulator_wake_out), .power_good_n(power_good_n));
   always #10 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         nFail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk({31'h0, pready}, 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // gap between enable pulses, after settling on the new ratio
   task automatic gap(input logic core, input int exp);
      int g;
      for (int k = 0; k < 3; k++) begin
         g = 0;
         do begin
            @(posedge clk);
            g++;
         end while ((core ? coreClkEn : sysClkEn) !== 1'b1 && g < 300);
      end
      chk(32'(g), 32'(exp));
   endtask
   task automatic test_done;
      $display("checks %0d failures %0d", numChecks, nFail);
      if (nFail == 0 && numChecks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      nFail++;
      test_done();
   end
   initial begin
      clk = 1'b0;
      {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
      wakeReset_n = 1'b1;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      repeat (60) @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         chk(rd, rstVal[i]);
      end
      chk({31'h0, clockOutOe}, 32'h1);
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `PLL_DIV_OFS, {26'h0, divCore[i], divSys[i]});
         gap(1'b0, int'(divSys[i]));
         gap(1'b1, 1 << divCore[i]);
      end
      apb(1'b1, `PLL_CTL_OFS, 32'h0000010C);
      gap(1'b0, 6);
      gap(1'b1, 6);
      apb(1'b1, `PLL_CTL_OFS, 32'h0000000C);
      gap(1'b1, 4);
      $display("test dividers done");
      apb(1'b1, `GLOBAL_CTL_OFS, 32'h0);
      repeat (3) @(posedge clk);
      chk({31'h0, clockOutOe}, 32'h0);
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, `GLOBAL_CTL_OFS, {30'h0, s[0], 1'b1});
         seen = 0;
         repeat (40) begin
            @(posedge clk);
            seen += (clock_out_pin === 1'b1);
         end
         chk(32'(clockOutOe === 1'b1 && (s[0] ? (seen >= 6 && seen <= 7) :
            (seen >= 18 && seen <= 22))), 32'h1);
      end
      $display("test clock out done");
      apb(1'b1, `VR_CTL_OFS, 32'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, regulator_wake_out}, 32'h0);
      apb(1'b0, `STATUS_OFS, 32'h0);
      chk(rd, 32'(PW_HIBER));
      wakeReset_n <= 1'b0;
      repeat (3) @(posedge clk);
      wakeReset_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk({31'h0, regulator_wake_out}, 32'h1);
      apb(1'b0, `STATUS_OFS, 32'h0);
      chk(rd, 32'(PW_WAIT));
      seen = 0;
      repeat (40) begin
         @(posedge clk);
         seen += (bootStart === 1'b1);
      end
      chk(32'(seen), 32'h1);
      apb(1'b0, `STATUS_OFS, 32'h0);
      chk(rd, 32'(PW_RUN));
      $display("test hibernate done");
      test_done();
   end
endmodule
`default_nettype wire

/* tb/reg_model.sv */
`timescale 1ns/1ps
`default_nettype none
module reg_model #(
   parameter int RAMP = 20
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic regulator_wake_out,
   output logic      power_good_n
);
   int rampCnt;
   // supply ramps while power requested, collapses once released
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rampCnt <= 0;
      end else if (!regulator_wake_out) begin
         rampCnt <= 0;
      end else if (rampCnt < RAMP) begin
         rampCnt <= rampCnt + 1;
      end
   end
   assign power_good_n = !(regulator_wake_out && rampCnt >= RAMP);
endmodule
`default_nettype wire
